// File: rtl/ipf_map.vh
// Widths, counts and encodings for the integer pipeline front end
`ifndef IPF_MAP_VH
`define IPF_MAP_VH
`define IPF_FETCH_W 128
`define IPF_FETCH_BYTES 16
`define IPF_QUEUE_BYTES 48
`define IPF_QPTR_W 6
`define IPF_QWRAP7 7'h30
`define IPF_QWRAP6 6'h30
`define IPF_LINE_BYTES 6'h10
`define IPF_NUM_REGS 8
`define IPF_ADDR_W 32
`define IPF_FPU_W 64
`define IPF_DATA_W 32
`define IPF_LEN_W 4
`define IPF_MAX_LEN 4'hF
`define IPF_LEN_ONE 4'h1
`define IPF_LEN_TWO 4'h2
`define IPF_LEN_THREE 4'h3
`define IPF_LEN_FIVE 4'h5
`define IPF_LEN_SIX 4'h6
// Instruction types
`define IPF_TYPE_W 3
`define IPF_T_ALU 3'h0
`define IPF_T_LOAD 3'h1
`define IPF_T_STORE 3'h2
`define IPF_T_JMP 3'h3
`define IPF_T_JCC 3'h4
`define IPF_T_FPU 3'h5
`define IPF_T_NOP 3'h6
// Opcode bytes understood by the simplified decoder
`define IPF_OP_NOP 8'h90
`define IPF_OP_JMP8 8'hEB
`define IPF_OP_JMP32 8'hE9
`define IPF_OP_JCC_LO 4'h7
`define IPF_OP_LOAD 8'h8B
`define IPF_OP_STORE 8'h89
`define IPF_OP_FPU_LO 8'hD8
`define IPF_OP_FPU_HI 8'hDF
`define IPF_OP_ALU_IMM 8'h05
`define IPF_MOD_REG 2'h3
`define IPF_MOD_D8 2'h1
`define IPF_MOD_D32 2'h2
// Microcode
`define IPF_UC_W 2
`define IPF_UC_PASS 2'h0
`define IPF_UC_ADD 2'h1
`define IPF_UC_MOVE 2'h2
`define IPF_UC_NONE 2'h3
`endif

// File: rtl/ipf_byte_queue.v
// Code byte queue between fetch and decode
`include "ipf_map.vh"
module ipf_byte_queue (
  input wire sys_clk,
  input wire rst,
  input wire flush,
  input wire push,
  input wire [`IPF_FETCH_W-1:0] push_data,
  input wire [`IPF_QPTR_W-1:0] push_count,
  input wire pop,
  input wire [`IPF_LEN_W-1:0] pop_count,
  output wire [`IPF_QPTR_W-1:0] fill,
  output wire room,
  output wire [`IPF_FETCH_W-1:0] head
);
  reg [7:0] mem [0:`IPF_QUEUE_BYTES-1];
  reg [`IPF_QPTR_W-1:0] rd_ptr;
  reg [`IPF_QPTR_W-1:0] wr_ptr;
  reg [`IPF_QPTR_W-1:0] count;
  wire [`IPF_QPTR_W-1:0] pop_ext = {2'h0, pop_count};
  wire [`IPF_QPTR_W-1:0] pop_n = pop ? pop_ext : 6'h00;
  wire [`IPF_QPTR_W-1:0] push_n = push ? push_count : 6'h00;
  wire [6*`IPF_FETCH_BYTES-1:0] wr_slot;
  integer k;
  genvar i;

  assign fill = count;
  // Room for a whole fetch line; never exceeds 48 bytes
  assign room = (count <= (`IPF_QUEUE_BYTES - `IPF_FETCH_BYTES));

  // Head window, one byte per lane
  generate
    for (i = 0; i < `IPF_FETCH_BYTES; i = i + 1) begin : g_head
      localparam [6:0] lane = i;
      wire [6:0] idx = {1'b0, rd_ptr} + lane;
      wire [6:0] wi = (idx >= `IPF_QUEUE_BYTES) ? idx - `IPF_QWRAP7 : idx;
      assign head[8*i+7:8*i] = mem[wi[5:0]];
    end
  endgenerate

  // Write slot per lane, wrapping at queue size
  generate
    for (i = 0; i < `IPF_FETCH_BYTES; i = i + 1) begin : g_wr
      localparam [6:0] lane = i;
      wire [6:0] idx = {1'b0, wr_ptr} + lane;
      wire [6:0] wi = (idx >= `IPF_QUEUE_BYTES) ? idx - `IPF_QWRAP7 : idx;
      assign wr_slot[6*i+5:6*i] = wi[5:0];
    end
  endgenerate

  // One process writes the storage so it keeps a single driver
  always @(posedge sys_clk) begin
    if (push && !flush) begin
      for (k = 0; k < `IPF_FETCH_BYTES; k = k + 1) begin
        if (k < push_count)
          mem[wr_slot[6*k +: 6]] <= push_data[8*k +: 8];
      end
    end
  end

  // Pointers; flush discards everything after a redirect
  always @(posedge sys_clk) begin
    if (rst || flush) begin
      rd_ptr <= 6'h00;
      wr_ptr <= 6'h00;
      count <= 6'h00;
    end else begin
      rd_ptr <= ({1'b0, rd_ptr} + pop_n >= `IPF_QUEUE_BYTES) ? rd_ptr + pop_n - `IPF_QWRAP6 : rd_ptr + pop_n;
      wr_ptr <= ({1'b0, wr_ptr} + push_n >= `IPF_QUEUE_BYTES) ? wr_ptr + push_n - `IPF_QWRAP6 : wr_ptr + push_n;
      count <= count + push_n - pop_n;
    end
  end
endmodule

// File: rtl/ipf_length_decoder.v
// Length and type decode of the instruction at the queue head
`include "ipf_map.vh"
module ipf_length_decoder (
  input wire [`IPF_FETCH_W-1:0] head,
  output reg [`IPF_LEN_W-1:0] length,
  output reg [`IPF_TYPE_W-1:0] itype,
  output reg has_mem,
  output reg [`IPF_ADDR_W-1:0] disp,
  output reg [2:0] base_reg,
  output reg [2:0] dst_reg
);
  wire [7:0] op = head[7:0];
  wire [7:0] modrm = head[15:8];
  wire [1:0] mode = modrm[7:6];

  // Simplified x86 subset: opcode plus optional modrm and displacement
  always @* begin
    length = `IPF_LEN_ONE;
    itype = `IPF_T_NOP;
    has_mem = 1'b0;
    disp = 32'h00000000;
    base_reg = modrm[2:0];
    dst_reg = modrm[5:3];
    if (op == `IPF_OP_JMP8) begin
      itype = `IPF_T_JMP;
      length = `IPF_LEN_TWO;
      disp = {{24{head[15]}}, head[15:8]};
    end else if (op == `IPF_OP_JMP32) begin
      itype = `IPF_T_JMP;
      length = `IPF_LEN_FIVE;
      disp = head[39:8];
    end else if (op[7:4] == `IPF_OP_JCC_LO) begin
      itype = `IPF_T_JCC;
      length = `IPF_LEN_TWO;
      disp = {{24{head[15]}}, head[15:8]};
    end else if (op == `IPF_OP_ALU_IMM) begin
      itype = `IPF_T_ALU;
      length = `IPF_LEN_FIVE;
      disp = head[39:8];
      dst_reg = 3'h0;
    end else if (op == `IPF_OP_LOAD || op == `IPF_OP_STORE ||
                 (op >= `IPF_OP_FPU_LO && op <= `IPF_OP_FPU_HI)) begin
      itype = (op == `IPF_OP_LOAD) ? `IPF_T_LOAD : (op == `IPF_OP_STORE) ? `IPF_T_STORE : `IPF_T_FPU;
      has_mem = (mode != `IPF_MOD_REG);
      if (mode == `IPF_MOD_D8) begin
        length = `IPF_LEN_THREE;
        disp = {{24{head[23]}}, head[23:16]};
      end else if (mode == `IPF_MOD_D32) begin
        length = `IPF_LEN_SIX;
        disp = head[47:16];
      end else begin
        length = `IPF_LEN_TWO;
      end
    end
  end
endmodule

// File: rtl/ipf_pipeline.v
// Integer pipeline front end: fetch, decode, two address stages, execute, write-back
`include "ipf_map.vh"

// What this block does
// - Six stages: fetch, decode, first address, second address, execute, write-back
// - Fetch reads 128 code bits per cycle
// - Predict targets for conditional and unconditional branches
// - Redirect fetch to predicted target two cycles after decode
// - Queue holds at most 48 code bytes
// - Decode finds length and type of instructions
// - Decode completes at most one instruction per cycle
// - First address stage computes linear operand address
// - Second stage does checks, cache, register reads
// - Second stage sends float instructions to FPU
// - Microcoded execution on delivered operands
// - Write-back updates registers or load/store unit
// - FPU path is 64 bits wide
module ipf_pipeline (
  input wire sys_clk,
  input wire rst,
  input wire [`IPF_ADDR_W-1:0] reset_pc,
  output reg [`IPF_ADDR_W-1:0] icache_addr,
  output wire icache_req,
  input wire icache_ack,
  input wire [`IPF_FETCH_W-1:0] icache_data,
  output reg [`IPF_ADDR_W-1:0] dcache_addr,
  output reg dcache_req,
  input wire [`IPF_DATA_W-1:0] dcache_data,
  input wire [`IPF_ADDR_W-1:0] seg_limit,
  output reg mem_fault,
  output reg fpu_valid,
  input wire fpu_ready,
  output reg [7:0] fpu_opcode,
  output reg [`IPF_FPU_W-1:0] fpu_operand,
  output reg ls_valid,
  output reg [`IPF_ADDR_W-1:0] ls_addr,
  output reg [`IPF_DATA_W-1:0] ls_data,
  output reg rf_we,
  output reg [2:0] rf_waddr,
  output reg [`IPF_DATA_W-1:0] rf_wdata,
  output reg [`IPF_ADDR_W-1:0] retire_pc
);
  // Register file
  reg [`IPF_DATA_W-1:0] regs [0:7];
  // Fetch state
  reg [`IPF_ADDR_W-1:0] fetch_pc;
  reg [`IPF_ADDR_W-1:0] dec_pc;
  reg redirect;
  reg [`IPF_ADDR_W-1:0] redirect_pc;
  wire [`IPF_QPTR_W-1:0] q_fill;
  wire q_room;
  wire [`IPF_FETCH_W-1:0] q_head;
  // Decode outputs
  wire [`IPF_LEN_W-1:0] d_len;
  wire [`IPF_TYPE_W-1:0] d_type;
  wire d_mem;
  wire [`IPF_ADDR_W-1:0] d_disp;
  wire [2:0] d_base;
  wire [2:0] d_dst;
  // Stage one of address calculation
  reg a1_v;
  reg [`IPF_TYPE_W-1:0] a1_type;
  reg a1_mem;
  reg [`IPF_ADDR_W-1:0] a1_disp;
  reg [2:0] a1_base;
  reg [2:0] a1_dst;
  reg [7:0] a1_op;
  reg [`IPF_ADDR_W-1:0] a1_pc;
  // Stage two
  reg a2_v;
  reg [`IPF_TYPE_W-1:0] a2_type;
  reg a2_mem;
  reg [`IPF_ADDR_W-1:0] a2_lin;
  reg [`IPF_ADDR_W-1:0] a2_imm;
  reg [2:0] a2_dst;
  reg [7:0] a2_op;
  reg [`IPF_ADDR_W-1:0] a2_pc;
  // Execute
  reg ex_v;
  reg [`IPF_UC_W-1:0] ex_uc;
  reg [`IPF_ADDR_W-1:0] ex_addr;
  reg [`IPF_DATA_W-1:0] ex_a;
  reg [`IPF_DATA_W-1:0] ex_b;
  reg [2:0] ex_dst;
  reg ex_store;
  reg [`IPF_ADDR_W-1:0] ex_pc;
  integer r;

  // FPU back-pressure holds the whole back end
  wire fpu_stall = fpu_valid && !fpu_ready;
  wire adv = !fpu_stall;

  // Register writers still in flight
  wire a1_writes = a1_v && (a1_type == `IPF_T_ALU || a1_type == `IPF_T_LOAD);
  wire a2_writes = a2_v && (a2_type == `IPF_T_ALU || a2_type == `IPF_T_LOAD);
  wire ex_writes = ex_v && (ex_uc == `IPF_UC_ADD || ex_uc == `IPF_UC_MOVE);
  // No forwarding: decode waits until the register file holds every result
  wire raw_hold = a1_writes || a2_writes || ex_writes || rf_we;

  // Decode needs all bytes of the next instruction present
  wire d_full_window = (q_fill >= {2'h0, `IPF_MAX_LEN});
  wire d_enough = (q_fill >= {2'h0, d_len}) && (q_fill != 6'h00);
  wire d_ok = d_full_window || d_enough;
  wire d_fire = d_ok && adv && !redirect && !raw_hold;
  wire is_branch = (d_type == `IPF_T_JMP) || (d_type == `IPF_T_JCC);
  // Backward conditionals predicted taken, forward not; jumps always taken
  wire jcc_back = (d_type == `IPF_T_JCC) && d_disp[31];
  wire pred_taken = d_fire && ((d_type == `IPF_T_JMP) || jcc_back);
  wire [`IPF_ADDR_W-1:0] next_dec_pc = dec_pc + {28'h0000000, d_len};
  wire [`IPF_ADDR_W-1:0] pred_target = next_dec_pc + d_disp;
  wire [`IPF_QPTR_W-1:0] fetch_bytes = `IPF_LINE_BYTES - {2'h0, fetch_pc[3:0]};
  wire fetch_take = icache_ack && !redirect;

  // Fetch always moves on to the next aligned line
  wire [`IPF_ADDR_W-1:0] next_line_pc = {fetch_pc[31:4] + 28'h0000001, 4'h0};

  // Second address stage limit check; a faulting instruction goes no further, except that a float one is still sent to the FPU
  wire a2_fault = a2_v && a2_mem && (a2_lin > seg_limit);
  wire a2_load = a2_v && a2_mem && (a2_type != `IPF_T_STORE) && !a2_fault;
  wire a2_fpu = a2_v && (a2_type == `IPF_T_FPU);

  // Write-back moves only while the FPU is not holding the back end
  wire wb_fire = adv && ex_v;
  wire wb_write = wb_fire && (ex_uc == `IPF_UC_ADD || ex_uc == `IPF_UC_MOVE);

  // Fetch asks only while the queue has room for a full line
  assign icache_req = q_room && !rst && !redirect;
  always @* begin
    icache_addr = fetch_pc;
  end

  ipf_byte_queue u_queue (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(redirect),
    .push(fetch_take),
    .push_data(icache_data >> {fetch_pc[3:0], 3'h0}),
    .push_count(fetch_bytes),
    .pop(d_fire),
    .pop_count(d_len),
    .fill(q_fill),
    .room(q_room),
    .head(q_head)
  );

  ipf_length_decoder u_dec (
    .head(q_head),
    .length(d_len),
    .itype(d_type),
    .has_mem(d_mem),
    .disp(d_disp),
    .base_reg(d_base),
    .dst_reg(d_dst)
  );

  // Fetch stage; a predicted branch sets redirect on the next edge and moves fetch_pc to the target on the edge after
  always @(posedge sys_clk) begin
    if (rst) begin
      fetch_pc <= reset_pc;
      dec_pc <= reset_pc;
      redirect <= 1'b0;
      redirect_pc <= 32'h00000000;
    end else if (redirect) begin
      fetch_pc <= redirect_pc;
      dec_pc <= redirect_pc;
      redirect <= 1'b0;
    end else begin
      if (fetch_take)
        fetch_pc <= next_line_pc;
      if (d_fire)
        dec_pc <= next_dec_pc;
      if (pred_taken && is_branch) begin
        redirect <= 1'b1;
        redirect_pc <= pred_target;
      end
    end
  end

  // Decode to first address stage
  always @(posedge sys_clk) begin
    if (rst) begin
      a1_v <= 1'b0;
      a1_type <= `IPF_T_NOP;
      a1_mem <= 1'b0;
      a1_disp <= 32'h00000000;
      a1_base <= 3'h0;
      a1_dst <= 3'h0;
      a1_op <= 8'h00;
      a1_pc <= 32'h00000000;
    end else if (adv) begin
      a1_v <= d_fire;
      a1_type <= d_type;
      a1_mem <= d_mem;
      a1_disp <= d_disp;
      a1_base <= d_base;
      a1_dst <= d_dst;
      a1_op <= q_head[7:0];
      a1_pc <= dec_pc;
    end
  end

  // First address stage: base plus displacement
  always @(posedge sys_clk) begin
    if (rst) begin
      a2_v <= 1'b0;
      a2_type <= `IPF_T_NOP;
      a2_mem <= 1'b0;
      a2_lin <= 32'h00000000;
      a2_imm <= 32'h00000000;
      a2_dst <= 3'h0;
      a2_op <= 8'h00;
      a2_pc <= 32'h00000000;
    end else if (adv) begin
      a2_v <= a1_v;
      a2_type <= a1_type;
      a2_mem <= a1_mem;
      a2_lin <= a1_mem ? regs[a1_base] + a1_disp : 32'h00000000;
      a2_imm <= a1_disp;
      a2_dst <= a1_dst;
      a2_op <= a1_op;
      a2_pc <= a1_pc;
    end
  end

  // Second address stage: limit check, cache access, register read, FPU dispatch
  always @(posedge sys_clk) begin
    if (rst) begin
      ex_v <= 1'b0;
      ex_uc <= `IPF_UC_NONE;
      ex_addr <= 32'h00000000;
      ex_a <= 32'h00000000;
      ex_b <= 32'h00000000;
      ex_dst <= 3'h0;
      ex_store <= 1'b0;
      ex_pc <= 32'h00000000;
      dcache_req <= 1'b0;
      dcache_addr <= 32'h00000000;
      mem_fault <= 1'b0;
      fpu_valid <= 1'b0;
      fpu_opcode <= 8'h00;
      fpu_operand <= 64'h0000000000000000;
    end else begin
      if (fpu_valid && fpu_ready)
        fpu_valid <= 1'b0;
      // Fault and load strobes are one-cycle pulses, quiet during a stall
      mem_fault <= adv && a2_fault;
      dcache_req <= adv && a2_load;
      if (adv) begin
        dcache_addr <= a2_lin;
        ex_v <= a2_v && !a2_fpu && !a2_fault;
        ex_addr <= a2_lin;
        ex_a <= regs[a2_dst];
        ex_b <= a2_imm;
        ex_dst <= a2_dst;
        ex_store <= (a2_type == `IPF_T_STORE);
        ex_pc <= a2_pc;
        case (a2_type)
          `IPF_T_ALU: ex_uc <= `IPF_UC_ADD;
          `IPF_T_LOAD: ex_uc <= `IPF_UC_MOVE;
          `IPF_T_STORE: ex_uc <= `IPF_UC_PASS;
          default: ex_uc <= `IPF_UC_NONE;
        endcase
        if (a2_fpu) begin
          fpu_valid <= 1'b1;
          fpu_opcode <= a2_op;
          fpu_operand <= {a2_lin, a2_imm};
        end
      end
    end
  end

  // Microcoded execute and write-back
  always @(posedge sys_clk) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_waddr <= 3'h0;
      rf_wdata <= 32'h00000000;
      ls_valid <= 1'b0;
      ls_addr <= 32'h00000000;
      ls_data <= 32'h00000000;
      retire_pc <= 32'h00000000;
    end else begin
      rf_we <= wb_write;
      rf_waddr <= ex_dst;
      rf_wdata <= (ex_uc == `IPF_UC_ADD) ? ex_a + ex_b : dcache_data;
      ls_valid <= wb_fire && ex_store;
      ls_addr <= ex_addr;
      ls_data <= ex_a;
      if (wb_fire)
        retire_pc <= ex_pc;
    end
  end

  // Register file update from write-back; cleared so address math never sees unknowns
  always @(posedge sys_clk) begin
    if (rst) begin
      for (r = 0; r < `IPF_NUM_REGS; r = r + 1)
        regs[r] <= 32'h00000000;
    end else if (rf_we) begin
      regs[rf_waddr] <= rf_wdata;
    end
  end
endmodule

// File: tb/ipf_pipeline_assertions.sv
// Port-level checks on the integer pipeline front end
module ipf_pipeline_checker (
  input wire sys_clk,
  input wire rst,
  input wire [31:0] reset_pc,
  input wire [31:0] icache_addr,
  input wire icache_req,
  input wire dcache_req,
  input wire mem_fault,
  input wire fpu_valid,
  input wire fpu_ready,
  input wire [7:0] fpu_opcode,
  input wire [63:0] fpu_operand,
  input wire ls_valid,
  input wire rf_we
);
  // FPU offer not yet taken
  sequence fpu_waiting;
    fpu_valid && !fpu_ready;
  endsequence
  // Stall long enough for the freeze to reach the outputs
  sequence fpu_stalled;
    fpu_waiting [*2];
  endsequence
  sequence load_issued;
    dcache_req && !fpu_valid;
  endsequence

  reset_quiet_a: assert property (@(posedge sys_clk) rst && $past(rst) |-> !icache_req && !rf_we && !fpu_valid)
    else $error("pipeline active during reset");
  start_fetch_a: assert property (@(posedge sys_clk) $fell(rst) |-> ##[0:1] (icache_req && icache_addr == reset_pc))
    else $error("fetch did not start at the reset address");
  startup_quiet_a: assert property (@(posedge sys_clk) $fell(rst) |-> (!rf_we && !ls_valid && !fpu_valid) [*5])
    else $error("result appeared sooner than the stage count allows");
  fpu_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    fpu_waiting |=> fpu_valid && $stable(fpu_opcode) && $stable(fpu_operand))
    else $error("fpu offer changed before it was taken");
  fpu_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    fpu_valid |-> fpu_opcode >= 8'hD8 && fpu_opcode <= 8'hDF)
    else $error("non float opcode sent to the fpu");
  one_writer_a: assert property (@(posedge sys_clk) disable iff (rst) !(rf_we && ls_valid))
    else $error("register write and store in one cycle");
  load_write_a: assert property (@(posedge sys_clk) disable iff (rst) load_issued |-> ##[1:3] rf_we)
    else $error("load data never written back");
  fault_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) mem_fault |=> !mem_fault)
    else $error("fault flag held longer than one cycle");
  stall_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
    fpu_stalled |-> !rf_we && !ls_valid && !dcache_req)
    else $error("later stages moved during fpu stall");
endmodule

bind ipf_pipeline ipf_pipeline_checker chk_u (.sys_clk(sys_clk), .rst(rst), .reset_pc(reset_pc),
  .icache_addr(icache_addr), .icache_req(icache_req), .dcache_req(dcache_req), .mem_fault(mem_fault),
  .fpu_valid(fpu_valid), .fpu_ready(fpu_ready), .fpu_opcode(fpu_opcode), .fpu_operand(fpu_operand),
  .ls_valid(ls_valid), .rf_we(rf_we));

// File: tb/ipf_far_model.sv
// Behavioural cache and fpu on the far side of the pipeline
module ipf_far_model (
  input wire sys_clk,
  input wire rst,
  input wire [31:0] icache_addr,
  input wire icache_req,
  output logic icache_ack,
  output logic [127:0] icache_data,
  input wire [31:0] dcache_addr,
  input wire dcache_req,
  output logic [31:0] dcache_data,
  input wire fpu_valid,
  output logic fpu_ready,
  input wire fpu_hold,
  input wire slow
);
  logic [7:0] mem [0:1023];
  logic [127:0] line;
  logic phase;
  logic [31:0] junk;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h90;
    junk = 32'h0;
  end
  // Aligned 16-byte line, inverted when not acknowledged so stale data never looks valid
  always_comb begin
    for (int k = 0; k < 16; k++) line[k*8 +: 8] = mem[{icache_addr[9:4], k[3:0]}];
  end
  assign icache_ack = icache_req && (!slow || phase);
  assign icache_data = icache_ack ? line : ~line;
  // Slow mode answers every other cycle
  always @(posedge sys_clk) phase <= rst ? 1'b0 : !phase;
  // Load data stands while the request does, scrambled otherwise
  always @(posedge sys_clk) junk <= junk ^ 32'hA5A5A5A5;
  assign dcache_data = dcache_req ? ~dcache_addr : junk;
  // Takes the op at once unless the bench holds it
  assign fpu_ready = fpu_valid && !fpu_hold;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the integer pipeline front end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, icache_req, icache_ack, dcache_req, mem_fault, fpu_valid, fpu_ready;
  logic ls_valid, rf_we, fpu_hold, slow, saw_target;
  logic [31:0] reset_pc, icache_addr, dcache_addr, dcache_data, seg_limit, ls_addr, ls_data, rf_wdata, retire_pc;
  logic [31:0] w1, w2, w3;
  logic [127:0] icache_data;
  logic [7:0] fpu_opcode;
  logic [63:0] fpu_operand;
  logic [2:0] rf_waddr;
  integer fail_count, compares, cycles, rf_count;

  ipf_pipeline dut_u (.sys_clk(sys_clk), .rst(rst), .reset_pc(reset_pc), .icache_addr(icache_addr),
    .icache_req(icache_req), .icache_ack(icache_ack), .icache_data(icache_data), .dcache_addr(dcache_addr),
    .dcache_req(dcache_req), .dcache_data(dcache_data), .seg_limit(seg_limit), .mem_fault(mem_fault),
    .fpu_valid(fpu_valid), .fpu_ready(fpu_ready), .fpu_opcode(fpu_opcode), .fpu_operand(fpu_operand),
    .ls_valid(ls_valid), .ls_addr(ls_addr), .ls_data(ls_data), .rf_we(rf_we), .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata), .retire_pc(retire_pc));
  ipf_far_model far_u (.sys_clk(sys_clk), .rst(rst), .icache_addr(icache_addr), .icache_req(icache_req),
    .icache_ack(icache_ack), .icache_data(icache_data), .dcache_addr(dcache_addr), .dcache_req(dcache_req),
    .dcache_data(dcache_data), .fpu_valid(fpu_valid), .fpu_ready(fpu_ready), .fpu_hold(fpu_hold), .slow(slow));

  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard plus a counter of writes and a flag for the branch-target fetch
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (rf_we === 1'b1) rf_count = rf_count + 1;
    if (icache_req === 1'b1 && icache_addr === 32'h122) saw_target = 1;
    if (cycles == 6000) begin
      fail_count = fail_count + 1;
      results();
    end
  end

  task check(input [63:0] seen, input [63:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Reset held six cycles; inputs move on the falling edge
  task start(input [31:0] pc);
    @(negedge sys_clk);
    rst = 1;
    reset_pc = pc;
    repeat (6) @(negedge sys_clk);
    rst = 0;
    rf_count = 0;
    saw_target = 0;
  endtask

  // Bounded wait for a flag, sampled where outputs have settled
  task automatic wait_hi(ref logic s);
    integer n;
    for (n = 0; n < 60 && s !== 1'b1; n++) @(negedge sys_clk);
    check(s, 1'b1);
  endtask

  // Adds, store, load, branch over junk adds, fpu op held by the far side, then an add
  task straight_run;
    logic [7:0] code [0:44];
    code = '{8'h05, 8'h11, 8'h00, 8'h00, 8'h00, 8'h05, 8'h11, 8'h00, 8'h00, 8'h00,
      8'h89, 8'h80, 8'h00, 8'h10, 8'h00, 8'h00, 8'h8B, 8'h80, 8'h00, 8'h20, 8'h00, 8'h00,
      8'hEB, 8'h0A, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h05,
      8'hD8, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 45; i++) far_u.mem[256 + i] = code[i];
    fpu_hold = 1;
    start(32'h100);
    wait_hi(rf_we);
    w1 = rf_wdata;
    check(rf_waddr, 3'h0);
    @(negedge sys_clk);
    wait_hi(rf_we);
    w2 = rf_wdata;
    check(32'(w2 - w1), 32'h11);
    @(negedge sys_clk);
    wait_hi(ls_valid);
    check({ls_addr, ls_data}, {32'(w2 + 32'h1000), w2});
    @(negedge sys_clk);
    wait_hi(rf_we);
    w3 = rf_wdata;
    check(w3, 32'(~(w2 + 32'h2000)));
    wait_hi(fpu_valid);
    check(fpu_opcode, 8'hD8);
    check(fpu_operand, {w3, 32'h0});
    repeat (20) @(negedge sys_clk);
    check({fpu_valid, icache_req}, 2'b10);
    check({saw_target, rf_count[3:0]}, {1'b1, 4'h3});
    fpu_hold = 0;
    wait_hi(rf_we);
    check(rf_wdata, 32'(w3 + 32'h1));
    check(retire_pc, 32'h128);
  endtask

  // Load beyond the segment limit under a slow cache, after a mid-run reset
  task fault_run;
    far_u.mem[512] = 8'h8B;
    far_u.mem[513] = 8'h80;
    for (int i = 514; i < 517; i++) far_u.mem[i] = 8'h00;
    far_u.mem[517] = 8'hF0;
    seg_limit = 32'h0000FFFF;
    slow = 1;
    start(32'h200);
    wait_hi(mem_fault);
    repeat (20) @(negedge sys_clk);
    check(rf_count, 0);
  endtask

  initial begin
    rst = 1;
    reset_pc = 32'h0;
    seg_limit = 32'hFFFFFFFF;
    fpu_hold = 0;
    slow = 0;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    rf_count = 0;
    saw_target = 0;
    straight_run();
    fault_run();
    results();
  end
endmodule
